// ### eeprom_host.sv
// Host controller driving a byte-wide parallel EEPROM through its pins.
// Assumes pin inputs synchronous to i_mclk and one device on the bus.
`timescale 1ns/1ps
`default_nettype none

module eeprom_host
    import eeprom_host_pkg::*;
#(
    parameter logic [eeprom_host_pkg::CNT_W-1:0] WC_TIMEOUT_CYC =
        eeprom_host_pkg::CNT_W'(eeprom_host_pkg::WC_TMO_CYC)
) (
    input  wire logic                              i_mclk,
    input  wire logic                              i_rst_n,
    // User command side
    input  wire logic                              i_cmd_valid,
    output logic                                   o_cmd_ready,
    input  wire logic                              i_cmd_write,
    input  wire logic                              i_cmd_last,
    input  wire logic [eeprom_host_pkg::ADDR_W-1:0] i_cmd_addr,
    input  wire logic [eeprom_host_pkg::DATA_W-1:0] i_cmd_data,
    output logic                                   o_rd_valid,
    output logic [eeprom_host_pkg::DATA_W-1:0]     o_rd_data,
    output logic                                   o_wr_done,
    output logic                                   o_wr_timeout,
    output logic                                   o_busy,
    // Device pins
    output logic                                   o_ce_n,
    output logic                                   o_oe_n,
    output logic                                   o_we_n,
    output logic [eeprom_host_pkg::ADDR_W-1:0]     o_addr,
    output logic [eeprom_host_pkg::DATA_W-1:0]     o_data_out,
    output logic                                   o_data_oe,
    input  wire logic [eeprom_host_pkg::DATA_W-1:0] i_data_in
);
    import eeprom_host_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        state_e              state;     // Sequencer state
        logic [2:0]          cyc;       // Cycles within a phase
        logic [NB_W-1:0]     nbytes;    // Bytes loaded in this page
        logic [ADDR_W-1:PAGE_LSB] page; // Page of the open load
        logic                last;      // Current byte closes the page
        logic                prev_b6;   // Bit six of previous status read
        logic                have_prev; // A previous status read exists
        logic                ce_n;      // Select pin
        logic                oe_n;      // Gate pin
        logic                we_n;      // Write strobe pin
        logic [ADDR_W-1:0]   addr;      // Address pins
        logic [DATA_W-1:0]   dout;      // Data driven on writes
        logic                doe;       // Data drive enable
        logic [DATA_W-1:0]   rd_data;   // Last read result
        logic                rd_valid;  // Read result pulse
        logic                wr_done;   // Programming finished pulse
        logic                wr_tmo;    // Programming give-up pulse
    } host_s;

    localparam host_s HOST_RST = '{
        state: ST_IDLE, cyc: '0, nbytes: '0, page: '0, last: 1'b0,
        prev_b6: 1'b0, have_prev: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, addr: '0, dout: '0, doe: 1'b0, rd_data: '0,
        rd_valid: 1'b0, wr_done: 1'b0, wr_tmo: 1'b0
    };

    host_s             st_r;        // Registered state
    host_s             st_nxt;      // Next state
    logic              win_clr;     // Restart window timer at strobe fall
    logic              tmo_clr;     // Restart programming timer
    logic [CNT_W-1:0]  win_cnt;     // Cycles since last strobe fall
    logic [CNT_W-1:0]  tmo_cnt;     // Cycles spent polling
    logic              page_ok;     // Next byte may extend the page
    logic              take;        // Command accepted this cycle

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    // Time since the latest falling write strobe
    elapsed_ctr #(.W(CNT_W)) u_win_ctr (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_clear (win_clr),
        .o_count (win_cnt)
    );

    // Time spent waiting for programming to finish
    elapsed_ctr #(.W(CNT_W)) u_tmo_ctr (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_clear (tmo_clr),
        .o_count (tmo_cnt)
    );

    // ------------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------------
    // Extend only with same page, room left, and window time to spare
    assign page_ok = i_cmd_write
                  && (i_cmd_addr[ADDR_W-1:PAGE_LSB] == st_r.page)
                  && (st_r.nbytes < PAGE_BYTES)
                  && (win_cnt < PAGE_LIMIT_CYC);
    assign o_cmd_ready = (st_r.state == ST_IDLE)
                      || ((st_r.state == ST_PAGE_OPEN) && page_ok);
    assign take = i_cmd_valid && o_cmd_ready;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt          = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.wr_done  = 1'b0;
        st_nxt.wr_tmo   = 1'b0;
        win_clr         = 1'b0;
        tmo_clr         = 1'b0;
        unique case (st_r.state)
            // Start a read or the first byte of a page
            ST_IDLE: begin
                if (take) begin
                    st_nxt.addr = i_cmd_addr;
                    st_nxt.cyc  = '0;
                    if (i_cmd_write) begin
                        st_nxt.dout   = i_cmd_data;
                        st_nxt.page   = i_cmd_addr[ADDR_W-1:PAGE_LSB];
                        st_nxt.nbytes = '0;
                        st_nxt.last   = i_cmd_last;
                        st_nxt.state  = ST_WR_SETUP;
                    end else begin
                        st_nxt.state  = ST_RD_ACC;
                    end
                end
            end
            // Hold select and gate low for the access time
            ST_RD_ACC: begin
                st_nxt.cyc = st_r.cyc + CYC_ONE;
                if (st_r.cyc == RD_ACC_CYC - CYC_ONE) begin
                    st_nxt.rd_data  = i_data_in;
                    st_nxt.rd_valid = 1'b1;
                    st_nxt.state    = ST_IDLE;
                end
            end
            // Address settled before the strobe falls
            ST_WR_SETUP: begin
                st_nxt.cyc   = '0;
                st_nxt.state = ST_WR_PULSE;
                win_clr      = 1'b1;
            end
            // Strobe low long enough to be taken as a write
            ST_WR_PULSE: begin
                st_nxt.cyc = st_r.cyc + CYC_ONE;
                if (st_r.cyc == WE_LOW_CYC - CYC_ONE) begin
                    st_nxt.state = ST_WR_HOLD;
                end
            end
            // Data held past the rising strobe, then count the byte
            ST_WR_HOLD: begin
                st_nxt.nbytes = st_r.nbytes + NB_ONE;
                if (st_r.last || (st_nxt.nbytes == PAGE_BYTES)) begin
                    st_nxt.state = ST_SETTLE;
                end else begin
                    st_nxt.state = ST_PAGE_OPEN;
                end
            end
            // Wait for another byte of the same page or let it lapse
            ST_PAGE_OPEN: begin
                if (take) begin
                    st_nxt.addr  = i_cmd_addr;
                    st_nxt.dout  = i_cmd_data;
                    st_nxt.last  = i_cmd_last;
                    st_nxt.state = ST_WR_SETUP;
                end else if (win_cnt >= PAGE_LIMIT_CYC) begin
                    st_nxt.state = ST_SETTLE;
                end
            end
            // Let the load window expire so programming has begun
            ST_SETTLE: begin
                if (win_cnt >= SETTLE_CYC) begin
                    st_nxt.cyc       = '0;
                    st_nxt.have_prev = 1'b0;
                    st_nxt.state     = ST_POLL_ACC;
                    tmo_clr          = 1'b1;
                end
            end
            // Read the last written byte and judge both status bits
            ST_POLL_ACC: begin
                st_nxt.cyc = st_r.cyc + CYC_ONE;
                if (st_r.cyc == RD_ACC_CYC - CYC_ONE) begin
                    st_nxt.prev_b6   = i_data_in[BIT_TOG];
                    st_nxt.have_prev = 1'b1;
                    // Bit six steady and bit seven true means finished;
                    // a refused protected write ends here only if its bit seven matches the stored byte
                    if (st_r.have_prev
                        && (i_data_in[BIT_TOG] == st_r.prev_b6)
                        && (i_data_in[BIT_POLL] ==
                            st_r.dout[BIT_POLL])) begin
                        st_nxt.rd_data = i_data_in;
                        st_nxt.wr_done = 1'b1;
                        st_nxt.state   = ST_IDLE;
                    end else if (tmo_cnt >= WC_TIMEOUT_CYC) begin
                        st_nxt.wr_tmo  = 1'b1;
                        st_nxt.state   = ST_IDLE;
                    end else begin
                        st_nxt.state   = ST_POLL_GAP;
                    end
                end
            end
            // Gate high so the next status read is a fresh read
            ST_POLL_GAP: begin
                st_nxt.cyc   = '0;
                st_nxt.state = ST_POLL_ACC;
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase

        // Pins follow the next state so they change on one edge
        st_nxt.ce_n = !(st_nxt.state inside {ST_RD_ACC, ST_POLL_ACC,
                       ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD});
        st_nxt.oe_n = !(st_nxt.state inside {ST_RD_ACC,
                       ST_POLL_ACC});
        st_nxt.we_n = (st_nxt.state != ST_WR_PULSE);
        st_nxt.doe  = st_nxt.state inside {ST_WR_SETUP, ST_WR_PULSE,
                       ST_WR_HOLD};
    end

    // Register the whole state
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= HOST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_ce_n       = st_r.ce_n;
    assign o_oe_n       = st_r.oe_n;
    assign o_we_n       = st_r.we_n;
    assign o_addr       = st_r.addr;
    assign o_data_out   = st_r.dout;
    assign o_data_oe    = st_r.doe;
    assign o_rd_data    = st_r.rd_data;
    assign o_rd_valid   = st_r.rd_valid;
    assign o_wr_done    = st_r.wr_done;
    assign o_wr_timeout = st_r.wr_tmo;
    assign o_busy       = (st_r.state != ST_IDLE);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    write_combo_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !o_we_n |-> (!o_ce_n && o_oe_n))
        else $error("strobe low without select low and gate high");

    no_contend_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_data_oe |-> (o_oe_n && !o_ce_n))
        else $error("host drives data while device may drive");

    strobe_width_a: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        $fell(o_we_n) |-> !o_we_n ##1 !o_we_n ##1 o_we_n)
        else $error("write strobe not two cycles low");

    page_same_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ($fell(o_we_n) && (st_r.nbytes != '0))
        |-> (o_addr[ADDR_W-1:PAGE_LSB] == st_r.page))
        else $error("page address changed within a page load");

    page_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ($rose(win_clr) && (st_r.nbytes != '0))
        |-> (win_cnt < PAGE_WIN_CYC))
        else $error("next strobe fall too late for the page");

    page_max_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_r.state == ST_WR_HOLD) && (st_r.nbytes == PAGE_BYTES - NB_ONE)
        |=> (st_r.state == ST_SETTLE))
        else $error("page load ran past its size");

    read_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $fell(o_oe_n) |-> (!o_oe_n)[*3] ##1 o_oe_n)
        else $error("read gate not three cycles low");

    poll_late_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_r.state == ST_SETTLE) ##1 (st_r.state == ST_POLL_ACC)
        |-> (win_cnt > PAGE_WIN_CYC))
        else $error("status polling began inside the load window");

    done_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_wr_done |-> (o_rd_data[BIT_POLL] == o_data_out[BIT_POLL]))
        else $error("finish reported with bit seven not true");

endmodule

`default_nettype wire

// ### eeprom_host_pkg.sv
// Constants, states and timing for the parallel EEPROM host controller.
// Assumes a 20 MHz clock and a byte-wide EEPROM with no clock pin.
//
// What this block does
// - Write needs select, strobe low, gate high
// - One to 256 byte loads form one page
// - Host keeps page address bits fixed per page
// - Host issues next strobe within 100 us

package eeprom_host_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 17;          // Address lines
    localparam int DATA_W     = 8;           // Data lines
    localparam int PAGE_LSB   = 8;           // Lowest page address bit
    localparam int NB_W       = 9;           // Byte-load counter width
    localparam int CNT_W      = 18;          // Elapsed counter width
    localparam int BIT_POLL   = 7;           // Complement status bit
    localparam int BIT_TOG    = 6;           // Alternating status bit
    localparam logic [NB_W-1:0] PAGE_BYTES = 9'h100;  // Page size
    localparam logic [NB_W-1:0] NB_ONE     = 9'h001;  // Count step

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS       = 50;         // Clock period
    localparam int RD_ACC_NS    = 150;        // Read access allowance
    localparam int WE_LOW_NS    = 100;        // Write strobe low time
    localparam int PAGE_WIN_NS  = 100000;     // Byte load window
    localparam int WC_TMO_NS    = 10000000;   // Programming give-up
    // Least times round up, longest round down
    localparam logic [2:0] RD_ACC_CYC =
        3'((RD_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] WE_LOW_CYC =
        3'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] CYC_ONE    = 3'h1;
    localparam logic [CNT_W-1:0] PAGE_WIN_CYC =
        CNT_W'(PAGE_WIN_NS / CLK_NS);
    localparam logic [CNT_W-1:0] PAGE_MARGIN  = 18'h00008;
    localparam logic [CNT_W-1:0] PAGE_LIMIT_CYC = PAGE_WIN_CYC - PAGE_MARGIN;
    localparam logic [CNT_W-1:0] SETTLE_CYC   = PAGE_WIN_CYC + PAGE_MARGIN;
    localparam int WC_TMO_CYC = WC_TMO_NS / CLK_NS;

    // ------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,   // Deselected, waiting for a command
        ST_RD_ACC    = 9'h002,   // Plain read access
        ST_WR_SETUP  = 9'h004,   // Address and data set up
        ST_WR_PULSE  = 9'h008,   // Write strobe low
        ST_WR_HOLD   = 9'h010,   // Strobe high, data held
        ST_PAGE_OPEN = 9'h020,   // Page load window open
        ST_SETTLE    = 9'h040,   // Window lapsing, programming starts
        ST_POLL_ACC  = 9'h080,   // Status read access
        ST_POLL_GAP  = 9'h100    // Gate high between status reads
    } state_e;

endpackage

// ### elapsed_ctr.sv
// Saturating elapsed-cycle counter with synchronous clear.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module elapsed_ctr #(
    parameter int W = 18
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic         i_clear,
    output logic [W-1:0]      o_count
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] count;     // Cycles since last clear
    } ctr_s;

    ctr_s ctr_r;                 // Registered state
    ctr_s ctr_nxt;               // Next state

    // Count up, hold at all ones, restart on clear
    always_comb begin
        ctr_nxt = ctr_r;
        if (i_clear) begin
            ctr_nxt.count = '0;
        end else if (ctr_r.count != '1) begin
            ctr_nxt.count = ctr_r.count + W'(1);
        end
    end

    // Register the state
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctr_r <= '0;
        end else begin
            ctr_r <= ctr_nxt;
        end
    end

    assign o_count = ctr_r.count;

    // Clear lands as zero on the next edge
    clear_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_clear |=> (o_count == '0))
        else $error("counter did not clear");

endmodule

`default_nettype wire

// ### eeprom_model.sv
// Behavioural byte-wide EEPROM seen from the controller's pins.
// Assumes the controller moves its pins just after rising clock edges.
`timescale 1ns/1ps
`default_nettype none

module eeprom_model #(
    parameter int PROG_CYC = 400                // Programming time
) (
    input  wire logic        i_mclk,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic [16:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wdrv,            // Host drives the bus
    input  wire logic        i_protect,         // Writes refused
    input  wire logic        i_hold,            // Programming never ends
    output logic      [7:0]  o_bus,             // Resolved data lines
    output logic             o_busy
);
    // ------------------------------------------------------------------
    // Array, page buffer and status
    // ------------------------------------------------------------------
    logic [7:0]  mem [logic [16:0]];            // Stored bytes
    logic [16:0] pa [$];                        // Loaded addresses
    logic [7:0]  pd [$];                        // Loaded data
    logic [16:0] a_lat, last_a;                 // Latched addresses
    logic [7:0]  last_d;                        // Last loaded byte
    logic        loading = 1'b0;                // Page load open
    logic        tog     = 1'b0;                // Alternating bit
    int          win     = 0;                   // Cycles since strobe
    int          prog    = 0;                   // Programming left

    assign o_busy = loading || (prog > 0);
    initial o_bus = 8'h00;

    // Stored value, or status while programming
    function automatic logic [7:0] rd_f(input logic [16:0] a);
        logic [7:0] v;
        v = mem.exists(a) ? mem[a] : 8'hFF;
        if (prog > 0) begin
            v[6] = tog;
            if (a == last_a) v[7] = ~last_d[7];
        end
        return v;
    endfunction

    // Address at falling strobe, write only with gate high
    always @(negedge i_we_n) begin
        if (!i_ce_n && i_oe_n && !i_protect && prog == 0) begin
            a_lat   = i_addr;
            loading = 1'b1;
            win     = 0;
        end
    end

    // Data at rising strobe, at most one page
    always @(posedge i_we_n) begin
        if (loading && !i_ce_n && pa.size() < 256) begin
            pa.push_back(a_lat);
            pd.push_back(i_wdata);
            last_a = a_lat;
            last_d = i_wdata;
        end
    end

    // Window lapse, then self-timed programming
    always @(posedge i_mclk) begin
        if (loading) begin
            win++;
            if (win >= 2000) begin
                loading = 1'b0;
                prog    = PROG_CYC;
            end
        end else if (prog > 0 && !i_hold) begin
            prog--;
            if (prog == 0) begin
                foreach (pa[i]) mem[pa[i]] = pd[i];
                pa.delete();
                pd.delete();
            end
        end
    end

    // Each finished status read flips the alternating bit
    always @(posedge i_oe_n) begin
        if (prog > 0) tog = ~tog;
    end

    // Bus level: host data, read data, or a changing pattern when floated
    always @(negedge i_mclk) begin
        if (i_wdrv) o_bus <= i_wdata;
        else if (!i_ce_n && !i_oe_n) o_bus <= rd_f(i_addr);
        else o_bus <= ~o_bus;
    end
endmodule

`default_nettype wire

// ### tb_parallel_eeprom_byte_page_write.sv
// Self-checking bench for the EEPROM host controller.
// Assumes eeprom_host and eeprom_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module tb_parallel_eeprom_byte_page_write;
    import eeprom_host_pkg::*;
    logic              i_mclk, i_rst_n, i_cmd_valid, i_cmd_write;
    logic              i_cmd_last, o_cmd_ready, o_rd_valid, o_wr_done;
    logic              o_wr_timeout, o_busy, o_ce_n, o_oe_n, o_we_n;
    logic              o_data_oe, protect, hold, mbusy;
    logic [ADDR_W-1:0] i_cmd_addr, o_addr;
    logic [DATA_W-1:0] i_cmd_data, o_rd_data, o_data_out, bus;
    int                error_cnt = 0;
    int                n_checks  = 0;
    int                cyc       = 0;

    eeprom_host #(.WC_TIMEOUT_CYC(18'h00FA0)) dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
        .o_cmd_ready(o_cmd_ready), .i_cmd_write(i_cmd_write),
        .i_cmd_last(i_cmd_last), .i_cmd_addr(i_cmd_addr),
        .i_cmd_data(i_cmd_data), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_wr_done(o_wr_done),
        .o_wr_timeout(o_wr_timeout), .o_busy(o_busy), .o_ce_n(o_ce_n),
        .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr),
        .o_data_out(o_data_out), .o_data_oe(o_data_oe), .i_data_in(bus));

    eeprom_model mdl (
        .i_mclk(i_mclk), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
        .i_addr(o_addr), .i_wdata(o_data_out), .i_wdrv(o_data_oe),
        .i_protect(protect), .i_hold(hold), .o_bus(bus), .o_busy(mbusy));

    // Clock and hang limit
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Compare, command and wait tasks
    // ------------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t flag %b want %b", $time, got, exp);
        end
    endtask
    // Hold the request until a rising edge takes it
    task automatic cmd(input logic w, input logic l,
                       input logic [16:0] a, input logic [7:0] d);
        int k;
        @(negedge i_mclk);
        {i_cmd_valid, i_cmd_write, i_cmd_last} = {1'b1, w, l};
        {i_cmd_addr, i_cmd_data} = {a, d};
        #1;
        for (k = 0; k < 9000 && o_cmd_ready !== 1'b1; k++) begin
            @(negedge i_mclk);
            #1;
        end
        @(negedge i_mclk);
        i_cmd_valid = 1'b0;
    endtask
    task automatic rd(input logic [16:0] a, input logic [7:0] exp);
        int k;
        cmd(1'b0, 1'b0, a, 8'h00);
        for (k = 0; k < 8 && o_rd_valid !== 1'b1; k++) @(negedge i_mclk);
        chk1(o_rd_valid, 1'b1);
        chk8(o_rd_data, exp);
    endtask
    // End of programming, or the polling limit
    task automatic wdone(input logic to, input logic [7:0] exp);
        int k;
        for (k = 0; k < 12000 && (o_wr_done | o_wr_timeout) !== 1'b1; k++)
            @(negedge i_mclk);
        chk1(o_wr_done | o_wr_timeout, 1'b1);
        chk1(o_wr_timeout, to);
        chk1(mbusy, to);
        if (!to) chk8(o_rd_data, exp);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_byte;
        cmd(1'b1, 1'b1, 17'h00123, 8'h5A);
        wdone(1'b0, 8'h5A);
        rd(17'h00123, 8'h5A);
    endtask
    // Full page closes itself on its 256th byte
    task automatic t_page;
        for (int i = 0; i < 256; i++)
            cmd(1'b1, 1'b0, 17'h10300 + 17'(i), 8'(i));
        wdone(1'b0, 8'hFF);
        rd(17'h10300, 8'h00);
        rd(17'h103FF, 8'hFF);
    endtask
    // Two bytes, no last flag: window lapse starts programming
    task automatic t_lapse;
        cmd(1'b1, 1'b0, 17'h0A010, 8'h81);
        cmd(1'b1, 1'b0, 17'h0A0F0, 8'h7E);
        wdone(1'b0, 8'h7E);
        rd(17'h0A010, 8'h81);
    endtask
    task automatic t_timeout;
        int k;
        hold = 1'b1;
        cmd(1'b1, 1'b1, 17'h00400, 8'h33);
        wdone(1'b1, 8'h00);
        hold = 1'b0;
        for (k = 0; k < 900 && mbusy !== 1'b0; k++) @(negedge i_mclk);
        rd(17'h00400, 8'h33);
    endtask
    task automatic t_protect;
        protect = 1'b1;
        // Same bit seven as the stored byte, so steady status ends the poll
        cmd(1'b1, 1'b1, 17'h00123, 8'h25);
        wdone(1'b0, 8'h5A);
        protect = 1'b0;
    endtask

    task automatic results;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Reset, then every scenario in turn
    initial begin
        {i_rst_n, i_cmd_valid, i_cmd_write, i_cmd_last} = 4'h0;
        {i_cmd_addr, i_cmd_data, protect, hold} = '0;
        repeat (3) @(negedge i_mclk);
        chk8({3'h0, o_ce_n, o_oe_n, o_we_n, o_data_oe, o_busy}, 8'h1C);
        i_rst_n = 1'b1;
        t_byte();
        t_page();
        t_lapse();
        t_timeout();
        t_protect();
        results();
    end
endmodule

`default_nettype wire
